// [src/spds_map.vh]
`ifndef SPDS_MAP_VH
`define SPDS_MAP_VH
// Register addresses on the configuration port (9-bit address space)
`define SPDS_ADDR_PLL_SOFT_RESET    9'h008
`define SPDS_ADDR_CLKGEN_SOFT_RESET 9'h009
`define SPDS_ADDR_CORE_SOFT_RESET   9'h00a
`define SPDS_ADDR_PLL_POWER         9'h010
`define SPDS_ADDR_CLK_MGMT_CONFIG   9'h014
`define SPDS_ADDR_CLK_DIST_CONFIG   9'h020
`define SPDS_ADDR_LOGIC_BLOCK_EN    9'h022
`define SPDS_ADDR_COLUMN_MUX_EN     9'h028
`define SPDS_ADDR_FRONT_END_EN      9'h030
`define SPDS_ADDR_BIAS_EN           9'h040
`define SPDS_ADDR_CHARGE_PUMP_CFG   9'h048
`define SPDS_ADDR_SERIAL_TX_EN      9'h070
`define SPDS_ADDR_SEQ_CONTROL       9'h0c0
// Register count (the indices below are 4-bit)
`define SPDS_NREG                   13
// Register file indices, one entry per mapped address
`define SPDS_IDX_PLL_SOFT_RESET     4'h0
`define SPDS_IDX_CLKGEN_SOFT_RESET  4'h1
`define SPDS_IDX_CORE_SOFT_RESET    4'h2
`define SPDS_IDX_PLL_POWER          4'h3
`define SPDS_IDX_CLK_MGMT_CONFIG    4'h4
`define SPDS_IDX_CLK_DIST_CONFIG    4'h5
`define SPDS_IDX_LOGIC_BLOCK_EN     4'h6
`define SPDS_IDX_COLUMN_MUX_EN      4'h7
`define SPDS_IDX_FRONT_END_EN       4'h8
`define SPDS_IDX_BIAS_EN            4'h9
`define SPDS_IDX_CHARGE_PUMP_CFG    4'ha
`define SPDS_IDX_SERIAL_TX_EN       4'hb
`define SPDS_IDX_SEQ_CONTROL        4'hc
// Field positions
`define SPDS_SEQ_EN_BIT             0
`define SPDS_SHUTTER_LSB            1
`define SPDS_SHUTTER_MSB            6
`define SPDS_SUBSAMPLE_LSB          7
`define SPDS_SUBSAMPLE_MSB          8
`define SPDS_CP_ENABLE_LSB          0
`define SPDS_CP_ENABLE_MSB          1
// Values
`define SPDS_ZERO16                 16'h0000
`define SPDS_CORE_RESET_ASSERTED    16'h0999
`define SPDS_CLKGEN_RESET_ASSERTED  16'h0009
`define SPDS_PLL_RESET_ASSERTED     16'h0099
// Clock-stop watchdog: clock gaps longer than this many cycles count as stopped
`define SPDS_CLK_GAP_CYCLES         8'h10
// Device states
`define SPDS_ST_STANDBY             2'h0
`define SPDS_ST_IDLE                2'h1
`define SPDS_ST_RUNNING             2'h2
`define SPDS_ST_UNDEFINED           2'h3
`endif

// [src/spds_clk_watch.v]
`timescale 1ns/1ps
`default_nettype none
`include "spds_map.vh"
// Watches the sampled sensor input clock; flags a stop while not in reset
module spds_clk_watch (
  // Clock and reset
  input  wire       i_clock,
  input  wire       i_nrst,
  // Observed clock and reset state
  input  wire       i_sensor_clk,
  input  wire       i_in_reset,
  // Result
  output reg        o_unsafe_stop
);
  reg       clk_d;   // Previous sample of the sensor clock
  reg [7:0] gap;     // Cycles since the last sensor clock edge

  ////////////////////////////////////////////////////////////////////////
  // Count cycles without an edge; a stop outside reset loses PLL lock
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_d         <= 1'b0;
      gap           <= 8'h00;
      o_unsafe_stop <= 1'b0;
    end else begin
      clk_d <= i_sensor_clk;
      if (clk_d != i_sensor_clk) begin
        gap <= 8'h00;
      end else if (gap != `SPDS_CLK_GAP_CYCLES) begin
        gap <= gap + 8'h01;
      end
      // Sticky until device reset: state is unknown once lock is lost
      if (gap == `SPDS_CLK_GAP_CYCLES && !i_in_reset) begin
        o_unsafe_stop <= 1'b1; // [R10] [R11]
      end
    end
  end
endmodule // spds_clk_watch
`default_nettype wire

// [src/spds_sequencer.v]
// Summary of operation
// (R1) Writing 192 bit0 low stops acquisition, idle
// (R2) Host keeps mode bits when clearing enable
// (R3) Host disables tx, front end, column mux
// (R4) Host then charge pump, bias, soft reset
// (R5) After power down writes, device in standby
// (R6) Host writes 34, 32, then 9 for part two
// (R7) Value 0x200C or 0x2004 with PLL modes
// (R8) Value 0x2008 or 0x2000 without PLL
// (R9) Host stops PLL, resets it, writes 20
// (R10) Reset device before the input clock stops
// (R11) Watched clock is PLL or serial clock
// (R12) Rate, exposure, gain change in any state
// (R13) Windowing, subsampling change in any state
// (R14) Shutter mode changes only standby or idle
// (R15) Writing 192 bit0 high starts acquisition
// (R16) Static registers written only when stopped; block takes them in any state
// (R17) Writing zero to 10 releases soft reset
// (R18) Host orders the whole shutdown sequence
`timescale 1ns/1ps
`default_nettype none
`include "spds_map.vh"
module spds_sequencer (
  // Clock and reset
  input  wire        i_clock,
  input  wire        i_nrst,
  // Register write/read port (decoded configuration port)
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [8:0]  i_addr,
  input  wire [15:0] i_wdata,
  output reg  [15:0] o_rdata,
  output reg         o_rvalid,
  // Clock selection: 1 when the PLL is bypassed
  input  wire        i_pll_bypass,
  input  wire        i_pll_ref_clk,
  input  wire        i_serial_clk,
  // Block enables and status
  output wire        o_acquiring,
  output wire [1:0]  o_state,
  output wire        o_standby,
  output wire        o_core_in_reset,
  output wire        o_clocks_stopped,
  output wire        o_unsafe_stop,
  output wire        o_serial_tx_on,
  output wire        o_front_end_on,
  output wire        o_column_mux_on,
  output wire        o_bias_on,
  output wire        o_charge_pump_on,
  output wire        o_shutter_refused
);
  reg  [15:0] regs [0:`SPDS_NREG-1]; // Register file, one entry per address
  reg  [3:0]  widx;                  // Decoded index of i_addr
  reg         hit;                   // Address is mapped
  reg         shutter_refused;       // Sticky: shutter change attempted while running
  reg  [1:0]  state;                 // Current device state
  reg  [1:0]  next_state;            // State after this cycle
  wire [15:0] seq_ctl;               // Sequencer control word
  wire        sensor_clk;            // Clock the watchdog observes
  wire        in_reset;              // Core held in soft reset

  // Device states; the undefined state is only left through i_nrst
  localparam [1:0] ST_STANDBY   = `SPDS_ST_STANDBY;   // Soft reset held, blocks off
  localparam [1:0] ST_IDLE      = `SPDS_ST_IDLE;      // Configured, not grabbing frames
  localparam [1:0] ST_RUNNING   = `SPDS_ST_RUNNING;   // Sequencer grabbing frames
  localparam [1:0] ST_UNDEFINED = `SPDS_ST_UNDEFINED; // Clock lost outside reset

  ////////////////////////////////////////////////////////////////////////
  // Address decode to register index
  // Unmapped addresses clear hit, so writes to them are dropped and reads
  // return zero; the index then rests at entry zero but is never used.
  // Only the mapped addresses get storage, which keeps the file small.
  always @* begin
    hit  = 1'b1;
    widx = 4'h0;
    case (i_addr)
      `SPDS_ADDR_PLL_SOFT_RESET:    widx = `SPDS_IDX_PLL_SOFT_RESET;
      `SPDS_ADDR_CLKGEN_SOFT_RESET: widx = `SPDS_IDX_CLKGEN_SOFT_RESET;
      `SPDS_ADDR_CORE_SOFT_RESET:   widx = `SPDS_IDX_CORE_SOFT_RESET;
      `SPDS_ADDR_PLL_POWER:         widx = `SPDS_IDX_PLL_POWER;
      `SPDS_ADDR_CLK_MGMT_CONFIG:   widx = `SPDS_IDX_CLK_MGMT_CONFIG;
      `SPDS_ADDR_CLK_DIST_CONFIG:   widx = `SPDS_IDX_CLK_DIST_CONFIG;
      `SPDS_ADDR_LOGIC_BLOCK_EN:    widx = `SPDS_IDX_LOGIC_BLOCK_EN;
      `SPDS_ADDR_COLUMN_MUX_EN:     widx = `SPDS_IDX_COLUMN_MUX_EN;
      `SPDS_ADDR_FRONT_END_EN:      widx = `SPDS_IDX_FRONT_END_EN;
      `SPDS_ADDR_BIAS_EN:           widx = `SPDS_IDX_BIAS_EN;
      `SPDS_ADDR_CHARGE_PUMP_CFG:   widx = `SPDS_IDX_CHARGE_PUMP_CFG;
      `SPDS_ADDR_SERIAL_TX_EN:      widx = `SPDS_IDX_SERIAL_TX_EN;
      `SPDS_ADDR_SEQ_CONTROL:       widx = `SPDS_IDX_SEQ_CONTROL;
      default:                      hit  = 1'b0;
    endcase
  end

  // Sequencer control: enable bit, shutter field and subsampling field
  assign seq_ctl = regs[`SPDS_IDX_SEQ_CONTROL];

  ////////////////////////////////////////////////////////////////////////
  // Register storage; reset value zero means powered down, sequencer off
  // Every entry takes any value in any state, except that the shutter field
  // of the sequencer control word is frozen while frames are being grabbed.
  // The host keeps the static words untouched while running; the block does
  // not police that, since a stray static write only disturbs image quality.
  // One process per entry keeps each word's write enable local to it.
  genvar g;
  generate
    for (g = 0; g < `SPDS_NREG; g = g + 1) begin : g_reg
      always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
          regs[g] <= `SPDS_ZERO16;
        end else if (i_wr && hit && widx == g) begin
          if (g == `SPDS_IDX_SEQ_CONTROL && state == ST_RUNNING) begin
            // Shutter field frozen while running; enable and others take effect
            regs[g] <= {i_wdata[15:`SPDS_SHUTTER_MSB+1],
                        regs[g][`SPDS_SHUTTER_MSB:`SPDS_SHUTTER_LSB],
                        i_wdata[`SPDS_SEQ_EN_BIT]};            // [R14] [R13] [R1] [R15]
          end else begin
            regs[g] <= i_wdata; // Accepted in any state [R12] [R13] [R17]
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Sticky flag for a shutter change attempted while running
  // A rewrite of the same shutter value is harmless and is not flagged.
  // Only i_nrst clears it, so software can poll it after a whole sequence.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shutter_refused <= 1'b0;
    end else if (i_wr && hit && widx == `SPDS_IDX_SEQ_CONTROL && state == ST_RUNNING &&
                 i_wdata[`SPDS_SHUTTER_MSB:`SPDS_SHUTTER_LSB] !=
                 seq_ctl[`SPDS_SHUTTER_MSB:`SPDS_SHUTTER_LSB]) begin
      shutter_refused <= 1'b1; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port: one-cycle registered answer, unmapped reads return zero
  // Read data holds between reads so a slow host can pick it up late;
  // a write and a read in the same cycle return the old word.
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata  <= `SPDS_ZERO16;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= i_rd;
      if (i_rd) begin
        o_rdata <= hit ? regs[widx] : `SPDS_ZERO16;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Device state: soft reset means standby, else enable bit picks run/idle
  // Only the exact soft reset word counts as standby; any other value in
  // the core reset register releases it, as the soft power up step expects.
  assign in_reset = (regs[`SPDS_IDX_CORE_SOFT_RESET] == `SPDS_CORE_RESET_ASSERTED);

  // Lost clock outranks everything: the core state cannot be trusted then
  always @* begin
    if (o_unsafe_stop) begin
      next_state = ST_UNDEFINED; // [R10]
    end else if (in_reset) begin
      next_state = ST_STANDBY; // [R5]
    end else if (seq_ctl[`SPDS_SEQ_EN_BIT]) begin
      next_state = ST_RUNNING; // [R15]
    end else begin
      next_state = ST_IDLE; // [R1] [R17]
    end
  end

  // State register; state lags a register write by one more cycle
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_STANDBY;
    end else begin
      case (next_state)
        ST_STANDBY,
        ST_IDLE,
        ST_RUNNING,
        ST_UNDEFINED: state <= next_state;
        default:      state <= ST_STANDBY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock-stop watchdog on the PLL reference or bypass serial clock
  // The watched clock must be stopped only with the core in soft reset;
  // a stop outside reset is latched and parks the state as undefined.
  // Switching the bypass select may look like one edge; that only restarts
  // the gap count and can never raise a false alarm.
  assign sensor_clk = i_pll_bypass ? i_serial_clk : i_pll_ref_clk; // [R11]

  spds_clk_watch u_clk_watch (
    .i_clock       (i_clock),
    .i_nrst        (i_nrst),
    .i_sensor_clk  (sensor_clk),
    .i_in_reset    (in_reset),
    .o_unsafe_stop (o_unsafe_stop)
  );

  ////////////////////////////////////////////////////////////////////////
  // Block enables follow their registers; standby gates everything off
  assign o_state          = state;
  assign o_acquiring      = (state == ST_RUNNING); // [R1] [R15]
  assign o_standby        = (state == ST_STANDBY); // [R5]
  assign o_core_in_reset  = in_reset;
  // Clocks count as stopped only once both the generator and PLL resets hold
  assign o_clocks_stopped = (regs[`SPDS_IDX_CLKGEN_SOFT_RESET] == `SPDS_CLKGEN_RESET_ASSERTED) &&
                            (regs[`SPDS_IDX_PLL_SOFT_RESET] == `SPDS_PLL_RESET_ASSERTED);
  // Soft reset overrides every block enable so standby is always low power
  assign o_serial_tx_on   = !in_reset && (regs[`SPDS_IDX_SERIAL_TX_EN] != `SPDS_ZERO16);
  assign o_front_end_on   = !in_reset && (regs[`SPDS_IDX_FRONT_END_EN] != `SPDS_ZERO16);
  assign o_column_mux_on  = !in_reset && (regs[`SPDS_IDX_COLUMN_MUX_EN] != `SPDS_ZERO16);
  assign o_bias_on        = !in_reset && (regs[`SPDS_IDX_BIAS_EN] != `SPDS_ZERO16);
  // Charge pump runs only with its enable bits set (0x0200 is off)
  assign o_charge_pump_on = !in_reset &&
                            (regs[`SPDS_IDX_CHARGE_PUMP_CFG][`SPDS_CP_ENABLE_MSB:`SPDS_CP_ENABLE_LSB] != 2'h0); // [R5]
  assign o_shutter_refused = shutter_refused;
endmodule // spds_sequencer
`default_nettype wire

// [bench/spds_props.sv]
`timescale 1ns/1ps
`default_nettype none
// Checker on the sequencer ports
module spds_props (
  input wire logic        i_clock, i_nrst, i_wr, i_pll_bypass, i_pll_ref_clk, i_serial_clk,
  input wire logic [8:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0]  o_state,
  input wire logic        o_acquiring, o_standby, o_core_in_reset, o_unsafe_stop, o_shutter_refused,
  input wire logic        o_serial_tx_on, o_front_end_on, o_column_mux_on, o_bias_on, o_charge_pump_on
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  logic       wclk;   // Watched sensor clock
  logic       wlast;  // Its level one cycle back
  logic [4:0] still;  // Cycles it sat still outside reset, saturating
  assign wclk = i_pll_bypass ? i_serial_clk : i_pll_ref_clk;
  // Count still cycles; a clock edge or a reset core clears the count
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      still <= 5'h00;
      wlast <= 1'b0;
    end else begin
      wlast <= wclk;
      if (wclk != wlast || o_core_in_reset) still <= 5'h00;
      else if (still != 5'h1f) still <= still + 5'h01;
    end
  end
  sequence pd_write;
    i_wr && i_addr == 9'h00a && i_wdata == 16'h0999 && o_state != 2'h3;
  endsequence
  sequence pd_done;
    ##1 o_core_in_reset ##1 (o_state == 2'h0 && o_standby);
  endsequence
  chk_stop_idle: assert property (i_wr && i_addr == 9'h0c0 && !i_wdata[0] |-> ##2 !o_acquiring)
    else $error("sequencer still running after disable");
  chk_start_run: assert property (o_state == 2'h1 && i_wr && i_addr == 9'h0c0 && i_wdata[0]
    |-> ##2 o_state == 2'h2) else $error("sequencer did not start");
  chk_standby_entry: assert property (pd_write |-> pd_done)
    else $error("no standby after soft reset");
  chk_blocks_off: assert property (o_core_in_reset |-> !(o_serial_tx_on || o_front_end_on
    || o_column_mux_on || o_bias_on || o_charge_pump_on)) else $error("block enabled in soft reset");
  chk_reset_release: assert property (i_wr && i_addr == 9'h00a && i_wdata == 16'h0000
    |=> !o_core_in_reset) else $error("soft reset not released");
  chk_refuse_cause: assert property ($rose(o_shutter_refused)
    |-> $past(i_wr && i_addr == 9'h0c0 && o_acquiring)) else $error("refusal without running write");
  chk_refuse_sticky: assert property (o_shutter_refused |=> o_shutter_refused)
    else $error("refusal flag dropped");
  chk_unsafe_flag: assert property (still == 5'h18 |-> o_unsafe_stop)
    else $error("clock stop out of reset not flagged");
  chk_undefined_state: assert property (o_unsafe_stop |-> ##[0:2] o_state == 2'h3)
    else $error("unsafe stop without undefined state");
endmodule // spds_props
bind spds_sequencer spds_props spds_props_i (.i_clock, .i_nrst, .i_wr, .i_pll_bypass, .i_pll_ref_clk,
  .i_serial_clk, .i_addr, .i_wdata, .o_state, .o_acquiring, .o_standby, .o_core_in_reset, .o_unsafe_stop,
  .o_shutter_refused, .o_serial_tx_on, .o_front_end_on, .o_column_mux_on, .o_bias_on, .o_charge_pump_on);
`default_nettype wire

// [bench/spds_host.sv]
`timescale 1ns/1ps
`default_nettype none
// Host model: register writes and reads, and the two sensor clocks
module spds_host (
  input  wire logic        i_clock, i_rvalid, i_ref_run, i_ser_run,
  input  wire logic [15:0] i_rdata,
  output var  logic        o_wr, o_rd, o_ref_clk, o_ser_clk,
  output var  logic [8:0]  o_addr,
  output var  logic [15:0] o_wdata
);
  logic [1:0] ph;  // Half period of four cycles, well inside the watch gap
  initial begin
    {o_wr, o_rd, o_ref_clk, o_ser_clk, ph} = 6'h00;
    o_addr = 9'h000;
    o_wdata = 16'h0000;
  end
  // A stopped clock holds its level
  always @(posedge i_clock) begin
    ph <= ph + 2'h1;
    if (i_ref_run && ph == 2'h3) o_ref_clk <= ~o_ref_clk;
    if (i_ser_run && ph == 2'h3) o_ser_clk <= ~o_ser_clk;
  end
  // Each write ends before the next one starts
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge i_clock);
    o_wr <= 1'b1;
    o_addr <= a;
    o_wdata <= d;
    @(posedge i_clock);
    o_wr <= 1'b0;
    o_addr <= ~a;     // Released lines never keep the last value
    o_wdata <= ~d;
  endtask
  // Missing valid turns the answer unknown so it cannot match
  task automatic rd(input logic [8:0] a, output logic [15:0] d);
    @(posedge i_clock);
    o_rd <= 1'b1;
    o_addr <= a;
    @(posedge i_clock);
    o_rd <= 1'b0;
    #1;
    d = i_rvalid ? i_rdata : 16'hxxxx;
  endtask
endmodule // spds_host
`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_clock, i_nrst, i_wr, i_rd, i_pll_bypass, i_pll_ref_clk, i_serial_clk, ref_run, ser_run;
  logic        o_rvalid, o_acquiring, o_standby, o_core_in_reset, o_clocks_stopped, o_unsafe_stop;
  logic        o_serial_tx_on, o_front_end_on, o_column_mux_on, o_bias_on, o_charge_pump_on, o_shutter_refused;
  logic [8:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, rv;
  logic [1:0]  o_state;
  int          err_total, num_checks, cycles;
  spds_sequencer spds_sequencer_i (.i_clock, .i_nrst, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata, .o_rvalid,
    .i_pll_bypass, .i_pll_ref_clk, .i_serial_clk, .o_acquiring, .o_state, .o_standby, .o_core_in_reset,
    .o_clocks_stopped, .o_unsafe_stop, .o_serial_tx_on, .o_front_end_on, .o_column_mux_on, .o_bias_on,
    .o_charge_pump_on, .o_shutter_refused);
  spds_host spds_host_i (.i_clock, .i_rvalid(o_rvalid), .i_ref_run(ref_run), .i_ser_run(ser_run),
    .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd), .o_ref_clk(i_pll_ref_clk), .o_ser_clk(i_serial_clk),
    .o_addr(i_addr), .o_wdata(i_wdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    i_clock = 1'b0;
    forever #20 i_clock = ~i_clock;
  end
  // Hang guard
  always @(posedge i_clock) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // State follows a taken write on the next edge; waiting two edges leaves margin
  task automatic wait2;
    repeat (2) @(posedge i_clock);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [8:0] map [14] = '{9'h008, 9'h009, 9'h00a, 9'h010, 9'h014, 9'h020, 9'h022, 9'h028, 9'h030,
      9'h040, 9'h048, 9'h070, 9'h0c0, 9'h1ff};
    for (int i = 0; i < 14; i++) begin
      spds_host_i.rd(map[i], rv);
      chk(rv, 16'h0000, "reset value");
      spds_host_i.wr(map[i], {7'h2a, map[i]});
      spds_host_i.rd(map[i], rv);
      chk(rv, (i == 13) ? 16'h0000 : {7'h2a, map[i]}, "read back");
    end
    $display("t_regs done");
  endtask
  task automatic t_run;
    spds_host_i.wr(9'h0c0, 16'h0015);
    wait2;
    chk({o_acquiring, o_state}, 3'h6, "not running");
    spds_host_i.wr(9'h0c0, 16'h0014);
    wait2;
    chk({o_acquiring, o_state}, 3'h1, "not idle");
    spds_host_i.rd(9'h0c0, rv);
    chk(rv, 16'h0014, "mode bits lost");
    $display("t_run done");
  endtask
  task automatic t_shutter;
    spds_host_i.wr(9'h0c0, 16'h0003);
    wait2;
    spds_host_i.wr(9'h0c0, 16'h0185);
    wait2;
    chk(o_shutter_refused, 1'b1, "shutter change taken");
    spds_host_i.rd(9'h0c0, rv);
    chk(rv, 16'h0183, "shutter or subsample field");
    spds_host_i.wr(9'h014, 16'h0055);
    spds_host_i.rd(9'h014, rv);
    chk(rv, 16'h0055, "write while running lost");
    spds_host_i.wr(9'h0c0, 16'h0182);
    wait2;
    chk(o_state, 2'h1, "stop after refusal");
    $display("t_shutter done");
  endtask
  task automatic t_pwr;
    logic [8:0]  a [5] = '{9'h070, 9'h030, 9'h028, 9'h048, 9'h040};
    logic [15:0] up [5] = '{16'h0007, 16'h0001, 16'h0003, 16'h0203, 16'h0001};
    logic [15:0] dn [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0200, 16'h0000};
    for (int i = 0; i < 5; i++) spds_host_i.wr(a[i], up[i]);
    wait2;
    chk({o_serial_tx_on, o_front_end_on, o_column_mux_on, o_charge_pump_on, o_bias_on}, 5'h1f, "power up");
    for (int i = 0; i < 5; i++) spds_host_i.wr(a[i], dn[i]);
    wait2;
    chk({o_serial_tx_on, o_front_end_on, o_column_mux_on, o_charge_pump_on, o_bias_on}, 5'h00, "power down");
    spds_host_i.wr(9'h00a, 16'h0999);
    wait2;
    chk({o_standby, o_core_in_reset, o_state}, 4'hc, "standby");
    spds_host_i.wr(9'h00a, 16'h0000);
    wait2;
    chk(o_state, 2'h1, "soft reset release");
    spds_host_i.wr(9'h00a, 16'h0999);
    $display("t_pwr done");
  endtask
  task automatic t_clocks;
    logic [15:0] cv [4] = '{16'h200c, 16'h2004, 16'h2008, 16'h2000};
    for (int i = 0; i < 4; i++) begin
      i_pll_bypass <= i[1];
      spds_host_i.wr(9'h009, 16'h0000);
      spds_host_i.wr(9'h022, 16'h0000);
      spds_host_i.wr(9'h020, cv[i]);
      spds_host_i.wr(9'h009, 16'h0009);
      spds_host_i.wr(9'h010, 16'h0000);
      spds_host_i.wr(9'h008, 16'h0099);
      spds_host_i.wr(9'h014, 16'h0000);
      wait2;
      chk(o_clocks_stopped, 1'b1, "clocks not stopped");
      spds_host_i.rd(9'h020, rv);
      chk(rv, cv[i], "clock distribution value");
    end
    $display("t_clocks done");
  endtask
  task automatic t_unsafe;
    ref_run <= 1'b0;
    ser_run <= 1'b0;
    repeat (40) @(posedge i_clock);
    ser_run <= 1'b1;
    i_pll_bypass <= 1'b0;
    #1;
    chk(o_unsafe_stop, 1'b0, "stop in reset flagged");
    spds_host_i.wr(9'h00a, 16'h0000);
    repeat (30) @(posedge i_clock);
    #1;
    chk({o_unsafe_stop, o_state}, 3'h7, "reference stop unflagged");
    // Second reset in mid-run clears the sticky flag; then watch the serial clock
    @(posedge i_clock);
    i_nrst <= 1'b0;
    i_pll_bypass <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    repeat (40) @(posedge i_clock);
    #1;
    chk({o_unsafe_stop, o_state}, 3'h1, "stopped reference flagged in bypass");
    @(posedge i_clock);
    ser_run <= 1'b0;
    repeat (30) @(posedge i_clock);
    #1;
    chk({o_unsafe_stop, o_state}, 3'h7, "serial stop unflagged");
    $display("t_unsafe done");
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    err_total = 0;
    num_checks = 0;
    cycles = 0;
    i_nrst = 1'b0;
    i_pll_bypass = 1'b0;
    ref_run = 1'b1;
    ser_run = 1'b1;
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_regs;
    t_run;
    t_shutter;
    t_pwr;
    t_clocks;
    t_unsafe;
    end_sim;
  end
endmodule // tb_top
`default_nettype wire
